// ---- design/sdd_pkg.sv ----
/*
 * Package for the sigma-delta decimator result block: constants, widths and carrier structs.
 * Assumes one 250 MHz clock and an asynchronous active-high reset; no register bus.
 */
// Operation
// - Reference on by enable bit; buffer output when enabled.
// - Both bits clear leaves reference off, external used.
// - Auto power-down when idle; reference follows enable bit.
// - Eight input pairs; code 6 temperature, 7 shorted.
// - Per-channel gain select, six distinct settings.
// - Input and gain changes apply at decimation step.
// - Interrupt delay; at zero first request on fourth.
// - Third-order comb filter of the bit stream.
// - One result per output sample, modulator rate over OSR.
// - Modulator clock from source select and divider.
// - Output width 16 to 24 bits by OSR.
// - OSR 256, low access clear: bits 23 to 8.
// - OSR 32: result least bit reads zero.
// - Low access set: word read gives low 16.
// - Byte read gives low 8 filter bits.
// - Toggle set inverts low access on every read.
// - Writing toggle leaves low access until next access.
// - Result register per channel sets ready flag.
// - Ready flag clears on read or by software.
// - Format bit: offset binary or two's complement.
// - Synchronous step valid third conversion, async fourth.
// - Ratios up to 256, up to three channels.
package sdd_pkg;
	localparam int NUM_CH = 3;
	localparam int ACC_W = 25;
	localparam int RES_W = 24;
	localparam logic [2:0] TEMP_SENSOR_INPUT = 3'h6;
	localparam logic [2:0] SHORTED_OFFSET_INPUT = 3'h7;
	localparam logic [2:0] GAIN_MAX_CODE = 3'h5;
	localparam logic [2:0] OSR_DEFAULT = 3'h0;
	localparam logic [1:0] INTDLY_DEFAULT = 2'h0;
	localparam int INTDLY_BASE = 4;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	typedef enum logic [1:0] {SDD_FMT_OFFSET, SDD_FMT_TWOS, SDD_FMT_RSVD2, SDD_FMT_RSVD3} sdd_fmt_e;

	// Per-channel software configuration
	typedef struct packed {
		logic start;
		logic [2:0] input_pair_select;
		logic [2:0] pga_gain_select;
		logic [1:0] interrupt_delay_select;
		logic [2:0] oversampling_ratio_select;
		logic data_format_select;
		logic low_bits_access_wr;
		logic low_bits_access_val;
		logic low_bits_toggle;
	} sdd_cfg_s;

	// Per-channel result read request
	typedef struct packed {
		logic rd;
		logic byte_rd;
		logic flag_clr;
	} sdd_rd_s;
endpackage : sdd_pkg

// ---- design/sdd_top.sv ----
/*
 * Sigma-delta decimator result block: modulator clock divider, three sinc3 decimators,
 * result windowing, ready flags, interrupt delay and reference/power control.
 * Assumes modulator bit streams arrive asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
module sdd_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ref_enable_bit_i,
	input wire logic ref_buffer_out_enable_i,
	input wire logic [1:0] modulator_clock_source_i,
	input wire logic [2:0] modulator_clock_divider_i,
	input wire logic [3:0] mod_clk_src_i,
	input wire sdd_pkg::sdd_cfg_s [2:0] cfg_i,
	input wire sdd_pkg::sdd_rd_s [2:0] rd_i,
	input wire logic [2:0] mod_bit_i,
	output logic ref_on_o,
	output logic ref_buf_out_o,
	output logic mod_power_o,
	output logic mod_clk_o,
	output logic [8:0] mux_sel_o,
	output logic [8:0] gain_sel_o,
	output logic [47:0] result_o,
	output logic [2:0] result_ready_flag_o,
	output logic [2:0] irq_req_o,
	output logic [2:0] low_bits_access_o
);
	logic [3:0] src_s1_r, src_s2_r, src_d_r;
	logic [6:0] div_cnt_r;
	logic [2:0] bit_s1_r, bit_s2_r;
	logic [2:0] active_w;
	logic src_rise_w;
	logic div_tick_w;
	logic [6:0] div_max_w;

	// Sources sampled through two flops before the edge detector
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			src_s1_r <= 4'h0;
			src_s2_r <= 4'h0;
			src_d_r <= 4'h0;
			bit_s1_r <= 3'h0;
			bit_s2_r <= 3'h0;
		end
		else
		begin
			src_s1_r <= mod_clk_src_i;
			src_s2_r <= src_s1_r;
			src_d_r <= src_s2_r;
			bit_s1_r <= mod_bit_i;
			bit_s2_r <= bit_s1_r;
		end
	end

	assign src_rise_w = src_s2_r[modulator_clock_source_i] & ~src_d_r[modulator_clock_source_i];
	assign div_max_w = 7'((1 << modulator_clock_divider_i) - 1);
	assign div_tick_w = src_rise_w && (div_cnt_r >= div_max_w);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			div_cnt_r <= 7'h00;
		else if (src_rise_w)
			div_cnt_r <= div_tick_w ? 7'h00 : div_cnt_r + 7'h01;
	end

	assign ref_on_o = ref_enable_bit_i;
	assign ref_buf_out_o = ref_enable_bit_i & ref_buffer_out_enable_i;
	assign mod_power_o = |active_w;
	assign mod_clk_o = div_tick_w;

	genvar g;
	generate
		for (g = 0; g < sdd_pkg::NUM_CH; g++)
		begin : g_ch
			sdd_chan u_chan (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.tick_i(div_tick_w),
				.bit_i(bit_s2_r[g]),
				.cfg_i(cfg_i[g]),
				.rd_i(rd_i[g]),
				.active_o(active_w[g]),
				.mux_sel_o(mux_sel_o[3*g +: 3]),
				.gain_sel_o(gain_sel_o[3*g +: 3]),
				.result_o(result_o[16*g +: 16]),
				.flag_o(result_ready_flag_o[g]),
				.irq_o(irq_req_o[g]),
				.lsbacc_o(low_bits_access_o[g])
			);
		end
	endgenerate
endmodule : sdd_top

// One decimator channel
module sdd_chan (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic bit_i,
	input wire sdd_pkg::sdd_cfg_s cfg_i,
	input wire sdd_pkg::sdd_rd_s rd_i,
	output logic active_o,
	output logic [2:0] mux_sel_o,
	output logic [2:0] gain_sel_o,
	output logic [15:0] result_o,
	output logic flag_o,
	output logic irq_o,
	output logic lsbacc_o
);
	localparam int W = sdd_pkg::ACC_W;
	logic [W-1:0] i1_r, i2_r, i3_r, d1_r, d2_r, d3_r;
	localparam int RW = sdd_pkg::RES_W;
	logic [W-1:0] c2_w, c3_w, x_w;
	logic [8:0] dec_cnt_r;
	logic [8:0] osr_w;
	logic dec_w;
	logic [RW-1:0] filt_r;
	logic [RW-1:0] scaled_w, fmt_w;
	logic [15:0] word_w;
	logic [4:0] shift_w;
	logic [3:0] conv_cnt_r;
	logic [3:0] dly_need_w;
	logic new_w;
	logic read_w;

	assign active_o = cfg_i.start;
	assign osr_w = 9'(9'h020 << cfg_i.oversampling_ratio_select[1:0]);
	assign dec_w = tick_i && (dec_cnt_r == osr_w - 9'h001);
	assign x_w = {{(W-1){1'b0}}, bit_i};
	assign c2_w = i3_r - d1_r;
	assign c3_w = c2_w - d2_r;
	assign read_w = rd_i.rd;

	// Integrators at modulator rate, differencers at output rate
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			i1_r <= '0;
			i2_r <= '0;
			i3_r <= '0;
			d1_r <= '0;
			d2_r <= '0;
			d3_r <= '0;
			dec_cnt_r <= 9'h000;
			mux_sel_o <= 3'h0;
			gain_sel_o <= 3'h0;
			filt_r <= '0;
		end
		else if (!cfg_i.start)
		begin
			i1_r <= '0;
			i2_r <= '0;
			i3_r <= '0;
			d1_r <= '0;
			d2_r <= '0;
			d3_r <= '0;
			dec_cnt_r <= 9'h000;
			mux_sel_o <= cfg_i.input_pair_select;
			gain_sel_o <= (cfg_i.pga_gain_select > sdd_pkg::GAIN_MAX_CODE) ? sdd_pkg::GAIN_MAX_CODE : cfg_i.pga_gain_select;
		end
		else if (tick_i)
		begin
			i1_r <= i1_r + x_w;
			i2_r <= i2_r + i1_r;
			i3_r <= i3_r + i2_r;
			dec_cnt_r <= dec_w ? 9'h000 : dec_cnt_r + 9'h001;
			if (dec_w)
			begin
				d1_r <= i3_r;
				d2_r <= c2_w;
				d3_r <= c3_w;
				filt_r <= RW'(c3_w - d3_r);
				mux_sel_o <= cfg_i.input_pair_select;
				gain_sel_o <= (cfg_i.pga_gain_select > sdd_pkg::GAIN_MAX_CODE) ? sdd_pkg::GAIN_MAX_CODE : cfg_i.pga_gain_select;
			end
		end
	end

	// Filter gain is OSR^3; align full scale to bit 23
	assign shift_w = 5'(9 - 3 * cfg_i.oversampling_ratio_select[1:0]);
	assign scaled_w = RW'(filt_r << shift_w);
	assign fmt_w = cfg_i.data_format_select ? (scaled_w ^ 24'h800000) : scaled_w;
	assign word_w = rd_i.byte_rd ? {8'h00, fmt_w[7:0]}
		: (lsbacc_o ? fmt_w[15:0]
		: {fmt_w[23:9], fmt_w[8] & (cfg_i.oversampling_ratio_select[1:0] != 2'h0)});
	assign new_w = tick_i && dec_w && cfg_i.start;
	assign dly_need_w = 4'(sdd_pkg::INTDLY_BASE - cfg_i.interrupt_delay_select);

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			result_o <= sdd_pkg::RESULT_RESET;
			flag_o <= 1'b0;
			irq_o <= 1'b0;
			lsbacc_o <= 1'b0;
			conv_cnt_r <= 4'h0;
		end
		else
		begin
			if (read_w)
				result_o <= word_w;
			flag_o <= new_w | (flag_o & ~read_w & ~rd_i.flag_clr);
			if (!cfg_i.start)
				conv_cnt_r <= 4'h0;
			else if (new_w && conv_cnt_r < dly_need_w)
				conv_cnt_r <= conv_cnt_r + 4'h1;
			irq_o <= new_w && (conv_cnt_r + 4'h1 >= dly_need_w);
			if (cfg_i.low_bits_access_wr)
				lsbacc_o <= cfg_i.low_bits_access_val;
			else if (read_w && cfg_i.low_bits_toggle)
				lsbacc_o <= ~lsbacc_o;
		end
	end
endmodule : sdd_chan

// ---- sim/sdd_top_props.sv ----
/* Port checker for sdd_top.
 Assumes one clock and an async active-high reset. */
`timescale 1ns/100ps
module sdd_top_props (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ref_enable_bit_i,
	input wire logic ref_buffer_out_enable_i,
	input wire sdd_pkg::sdd_cfg_s [2:0] cfg_i,
	input wire sdd_pkg::sdd_rd_s [2:0] rd_i,
	input wire logic ref_on_o,
	input wire logic ref_buf_out_o,
	input wire logic mod_power_o,
	input wire logic [47:0] result_o,
	input wire logic [2:0] result_ready_flag_o,
	input wire logic [2:0] irq_req_o,
	input wire logic [2:0] low_bits_access_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_ref_follows_bit: assert property (ref_on_o == ref_enable_bit_i)
		else $error("reference enable wrong");
	a_buf_out_both: assert property (ref_buf_out_o == (ref_enable_bit_i && ref_buffer_out_enable_i))
		else $error("buffer output wrong");
	a_ext_ref_off: assert property (!ref_enable_bit_i && !ref_buffer_out_enable_i |-> !ref_on_o && !ref_buf_out_o)
		else $error("reference not off");
	a_power_follows: assert property (mod_power_o == (cfg_i[0].start | cfg_i[1].start | cfg_i[2].start))
		else $error("power state wrong");
	a_read_clears: assert property (rd_i[0].rd && result_ready_flag_o[0] |=> !result_ready_flag_o[0])
		else $error("flag not cleared by read");
	a_toggle_flips: assert property (rd_i[0].rd && cfg_i[0].low_bits_toggle |=> $changed(low_bits_access_o[0]))
		else $error("low access not toggled");
	a_lsb_holds: assert property (!rd_i[0].rd && !cfg_i[0].low_bits_access_wr |=> $stable(low_bits_access_o[0]))
		else $error("low access moved");
	a_osr32_lsb: assert property (rd_i[0].rd && !rd_i[0].byte_rd && !low_bits_access_o[0]
		&& cfg_i[0].oversampling_ratio_select == 3'h0 |=> !result_o[0])
		else $error("lsb not zero");
	a_byte_read: assert property (rd_i[0].rd && rd_i[0].byte_rd |=> result_o[15:8] == 8'h00)
		else $error("byte read wide");
	c_flag: cover property ($rose(result_ready_flag_o[0]));
	c_irq: cover property (irq_req_o[0]);
	c_toggle: cover property (rd_i[0].rd && cfg_i[0].low_bits_toggle);
endmodule : sdd_top_props
bind sdd_top sdd_top_props sdd_top_props_inst (.*);

// ---- sim/sdd_mod_model.sv ----
/* Modulator model: free clock, bit density three quarters.
 Assumes the block synchronises both lines. */
`timescale 1ns/100ps
module sdd_mod_model (
	output logic mclk_o,
	output logic [2:0] bit_o
);
	logic [1:0] ph_r = 2'h0;
	initial mclk_o = 1'b0;
	// Period unrelated to the system clock
	always #7 mclk_o = ~mclk_o;
	always @(posedge mclk_o)
		ph_r <= ph_r + 2'h1;
	assign bit_o = {3{ph_r != 2'h3}};
endmodule : sdd_mod_model

// ---- sim/test_sigma_delta_decimator_result.sv ----
/* Bench for sdd_top, inputs driven on falling edges.
 Assumes the modulator model on clock source 0. */
`timescale 1ns/100ps
module test_sigma_delta_decimator_result;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ref_en = 1'b0;
	logic buf_en = 1'b0;
	logic mclk, seen;
	logic [2:0] mbit, flag, irq, lsb;
	sdd_pkg::sdd_cfg_s [2:0] cfg = '0;
	sdd_pkg::sdd_rd_s [2:0] rd = '0;
	logic ref_on, buf_out, pwr;
	logic [8:0] mux, gain;
	logic [47:0] res;
	int fail_count = 0;
	int cmp_count = 0;
	initial forever #2 clk_i = ~clk_i;
	sdd_mod_model sdd_mod_model_inst (.mclk_o(mclk), .bit_o(mbit));
	sdd_top sdd_top_inst (.clk_i(clk_i), .reset_i(reset_i), .ref_enable_bit_i(ref_en),
		.ref_buffer_out_enable_i(buf_en), .modulator_clock_source_i(2'h0), .modulator_clock_divider_i(3'h0),
		.mod_clk_src_i({3'h0, mclk}), .cfg_i(cfg), .rd_i(rd), .mod_bit_i(mbit), .ref_on_o(ref_on),
		.ref_buf_out_o(buf_out), .mod_power_o(pwr), .mod_clk_o(), .mux_sel_o(mux), .gain_sel_o(gain),
		.result_o(res), .result_ready_flag_o(flag), .irq_req_o(irq), .low_bits_access_o(lsb));
	task check(input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task report_and_stop();
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task conv();
		int n;
		n = 0;
		seen = 1'b0;
		while (flag[0] !== 1'b1 && n < 3000)
		begin
			@(negedge clk_i);
			seen |= irq[0];
			n++;
		end
		@(negedge clk_i);
		seen |= irq[0];
		if (n >= 3000)
			fail_count++;
	endtask : conv
	task read(input logic b, input logic [15:0] e);
		@(negedge clk_i);
		rd[0].rd = 1'b1;
		rd[0].byte_rd = b;
		@(negedge clk_i);
		rd[0] = '0;
		@(negedge clk_i);
		check(res[15:0], e);
	endtask : read
	task clr();
		rd[0].flag_clr = 1'b1;
		@(negedge clk_i);
		rd[0] = '0;
		@(negedge clk_i);
		check(flag[0], 1'b0);
	endtask : clr
	initial
	begin
		#200000;
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (6) @(negedge clk_i);
		reset_i = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			{ref_en, buf_en} = i[1:0];
			@(negedge clk_i);
			check({ref_on, buf_out}, {ref_en, ref_en & buf_en});
		end
		check(pwr, 1'b0);
		cfg[0].oversampling_ratio_select = 3'h3;
		cfg[0].input_pair_select = sdd_pkg::TEMP_SENSOR_INPUT;
		cfg[0].pga_gain_select = 3'h7;
		cfg[0].start = 1'b1;
		@(negedge clk_i);
		check(pwr, 1'b1);
		for (int i = 1; i < 4; i++)
		begin
			conv();
			check(seen, 1'b0);
			clr();
		end
		conv();
		check(seen, 1'b1);
		read(1'b0, 16'hC000);
		check(flag[0], 1'b0);
		check({mux[2:0], gain[2:0]}, {3'h6, sdd_pkg::GAIN_MAX_CODE});
		cfg[0].input_pair_select = sdd_pkg::SHORTED_OFFSET_INPUT;
		repeat (2) @(negedge clk_i);
		check(mux[2:0], 3'h6);
		conv();
		check(mux[2:0], 3'h7);
		cfg[0].low_bits_toggle = 1'b1;
		@(negedge clk_i);
		check(lsb[0], 1'b0);
		read(1'b0, 16'hC000);
		check(lsb[0], 1'b1);
		read(1'b0, 16'h0000);
		cfg[0].low_bits_toggle = 1'b0;
		read(1'b1, 16'h0000);
		cfg[0].data_format_select = 1'b1;
		repeat (2)
		begin
			conv();
			clr();
		end
		conv();
		read(1'b0, 16'h4000);
		cfg[0].start = 1'b0;
		cfg[0].data_format_select = 1'b0;
		cfg[0].oversampling_ratio_select = 3'h0;
		@(negedge clk_i);
		cfg[0].start = 1'b1;
		repeat (4)
		begin
			conv();
			clr();
		end
		conv();
		read(1'b0, 16'hC000);
		report_and_stop();
	end
endmodule : test_sigma_delta_decimator_result
